/* src/saso_pkg.sv */
package saso_pkg;
  // ==========================================
  // serial word layout
  localparam int SAMPLE_WIDTH = 24;
  localparam int SLOT_BITS = 32;
  localparam int PAIR_WIDTH = 2 * SAMPLE_WIDTH;
  // ==========================================
  // clock divider, strap delay and buffer depth counts
  localparam int BIT_DIV = 4;
  localparam int FRAME_DIV = 256;
  localparam int FRAME_CNT_W = 8;
  localparam int STRAP_DELAY = 250;
  localparam int STRAP_CNT_W = 8;
  localparam int FIFO_DEPTH = 32;
  // ==========================================
  // high-pass filter: one-pole, corner near 1.9 Hz at 48 kHz, shift of 12
  localparam int HPF_SHIFT = 12;
  localparam int HPF_ACC_W = 40;
  typedef enum logic {SASO_FMT_LJ, SASO_FMT_I2S} saso_fmt_type;
endpackage : saso_pkg

/* src/saso_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module saso_fifo #(
  parameter int WIDTH = 96,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // read side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic full, empty, doWr, doRd;

  always_comb begin
    full = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
    empty = wrPtr_q == rdPtr_q;
    inReady = !full;
    outValid = !empty;
    doWr = inValid && !full;
    doRd = outReady && !empty;
    wrPtr_d = doWr ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d = doRd ? rdPtr_q + 1'b1 : rdPtr_q;
    outData = mem_q[rdPtr_q[AW-1:0]];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
    end
    if (doWr) begin
      mem_q[wrPtr_q[AW-1:0]] <= inData;
    end
  end
endmodule : saso_fifo
`default_nettype wire

/* src/saso_serial_out.sv */
// Functional notes
// RULE1: master clock is 256 times sample rate
// RULE2: master drives bit clock, master clock over 4
// RULE3: master drives channel clock, master over 256
// RULE4: role pin low master, high slave
// RULE5: slave never drives bit or channel clock
// RULE6: slave channel clock synchronous at sample rate
// RULE7: slave bit clock 48x to 128x, 64x preferred
// RULE8: 24-bit two's complement words, MSB first
// RULE9: output one full precision, two low delay
// RULE10: bit clock shifts, channel clock picks side
// RULE11: left and right words from same instant
// RULE12: two formats chosen by format pin
// RULE13: format pin high gives I2S, else left-justified
// RULE14: first-order DC-removing high-pass after decimator
// RULE15: modulator runs 64x or 128x, pairs out
// RULE16: sample pairs up to 100 kHz
// RULE17: pin roles fixed on entering operating mode
// RULE18: data pin strapped 250 clocks after reset
// RULE19: data changes on falling bit clock edge
// RULE20: bits after LSB driven low
`timescale 1ns/1ps
`default_nettype none
module saso_serial_out
  import saso_pkg::*;
#(
  parameter int WIDTH = saso_pkg::SAMPLE_WIDTH,
  parameter int DEPTH = saso_pkg::FIFO_DEPTH
) (
  // master clock and reset
  input wire logic clk,
  input wire logic rst,
  // decimated sample pairs
  input wire logic sampleValid,
  output logic sampleReady,
  input wire logic [WIDTH-1:0] fullLeft,
  input wire logic [WIDTH-1:0] fullRight,
  input wire logic [WIDTH-1:0] lowDelayLeft,
  input wire logic [WIDTH-1:0] lowDelayRight,
  // strap pins
  input wire logic roleSelect,
  input wire logic formatSelect,
  // bit clock pin
  input wire logic bitClockIn,
  output logic bitClockOut,
  output logic bitClockOeN,
  // channel clock pin
  input wire logic channelClockIn,
  output logic channelClockOut,
  output logic channelClockOeN,
  // first data pin, also the mode strap
  input wire logic fullPrecisionIn,
  output logic fullPrecisionOut,
  output logic fullPrecisionOeN,
  // second data pin
  output logic lowDelayOut,
  // status
  output logic controlPortMode,
  output logic standAlone
);
  // ==========================================
  // input synchronisers
  logic [4:0] sync1_q, sync2_q;
  always_ff @(posedge clk) begin
    sync1_q <= {roleSelect, formatSelect, bitClockIn, channelClockIn, fullPrecisionIn};
    sync2_q <= sync1_q;
  end
  logic roleS, fmtS, bclkS, lrckS, strapS;
  assign {roleS, fmtS, bclkS, lrckS, strapS} = sync2_q;

  // ==========================================
  // mode strap capture
  logic [STRAP_CNT_W-1:0] strapCnt_q, strapCnt_d;
  logic decided_q, decided_d, ctrl_q, ctrl_d, slave_q, slave_d;
  saso_fmt_type fmt_q, fmt_d;
  always_comb begin
    strapCnt_d = strapCnt_q;
    decided_d = decided_q;
    ctrl_d = ctrl_q;
    slave_d = slave_q;
    fmt_d = fmt_q;
    if (!decided_q) begin
      if (strapCnt_q == STRAP_CNT_W'(STRAP_DELAY - 1)) begin
        decided_d = 1'b1; // RULE18
        ctrl_d = strapS; // RULE18
        slave_d = roleS; // RULE4 RULE17
        fmt_d = fmtS ? SASO_FMT_I2S : SASO_FMT_LJ; // RULE12 RULE13 RULE17
      end else begin
        strapCnt_d = strapCnt_q + 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      strapCnt_q <= '0;
      decided_q <= 1'b0;
      ctrl_q <= 1'b0;
      slave_q <= 1'b0;
      fmt_q <= SASO_FMT_LJ;
    end else begin
      strapCnt_q <= strapCnt_d;
      decided_q <= decided_d;
      ctrl_q <= ctrl_d;
      slave_q <= slave_d;
      fmt_q <= fmt_d;
    end
  end
  logic running;
  assign running = decided_q && !ctrl_q;
  assign controlPortMode = ctrl_q;
  assign standAlone = running;

  // ==========================================
  // high-pass filter, y = x - dc; dc tracks the input slowly
  logic signed [HPF_ACC_W-1:0] dc_q [4];
  logic signed [HPF_ACC_W-1:0] dc_d [4];
  logic signed [WIDTH-1:0] hpIn [4];
  logic signed [WIDTH-1:0] hpOut [4];
  logic fifoInReady;
  logic take;
  assign hpIn[0] = fullLeft;
  assign hpIn[1] = fullRight;
  assign hpIn[2] = lowDelayLeft;
  assign hpIn[3] = lowDelayRight;
  assign take = sampleValid && fifoInReady;
  assign sampleReady = fifoInReady;
  for (genvar i = 0; i < 4; i++) begin : gHpf
    logic signed [HPF_ACC_W-1:0] diff;
    always_comb begin
      diff = HPF_ACC_W'(hpIn[i]) - (dc_q[i] >>> HPF_SHIFT);
      hpOut[i] = WIDTH'(diff); // RULE14
      dc_d[i] = take ? dc_q[i] + diff : dc_q[i]; // RULE14
    end
    always_ff @(posedge clk) begin
      if (rst) begin
        dc_q[i] <= '0;
      end else begin
        dc_q[i] <= dc_d[i];
      end
    end
  end

  // ==========================================
  // pair buffer keeps both channels of one instant together
  logic [4*WIDTH-1:0] fifoOut;
  logic fifoValid, fifoPop;
  saso_fifo #(.WIDTH(4 * WIDTH), .DEPTH(DEPTH)) uFifo (
    .clk(clk),
    .rst(rst),
    .inValid(sampleValid),
    .inReady(fifoInReady),
    .inData({hpOut[0], hpOut[1], hpOut[2], hpOut[3]}), // RULE11 RULE15 RULE16
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoOut)
  );

  // ==========================================
  // master clock dividers
  logic [FRAME_CNT_W-1:0] div_q, div_d;
  always_comb begin
    div_d = running ? div_q + 1'b1 : '0;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end
  logic mBclk, mLrck;
  assign mBclk = div_q[1]; // RULE2
  assign mLrck = div_q[FRAME_CNT_W-1]; // RULE3

  // ==========================================
  // effective clocks and edges; slave clocks track master clock by design
  logic bclk, channel_clock, bclkPrev_q, lrckPrev_q;
  assign bclk = slave_q ? bclkS : mBclk; // RULE4 RULE7
  assign channel_clock = slave_q ? lrckS : mLrck; // RULE6
  always_ff @(posedge clk) begin
    if (rst) begin
      bclkPrev_q <= 1'b0;
      lrckPrev_q <= 1'b0;
    end else begin
      bclkPrev_q <= bclk;
      lrckPrev_q <= channel_clock;
    end
  end
  logic bFall, lEdge;
  assign bFall = bclkPrev_q && !bclk;
  assign lEdge = lrckPrev_q != channel_clock;

  // ==========================================
  // shifter: high channel clock carries right in left-justified, left in I2S
  logic [PAIR_WIDTH-1:0] hold_q, hold_d;
  logic [WIDTH-1:0] sh1_q, sh1_d, sh2_q, sh2_d;
  logic [5:0] bitCnt_q, bitCnt_d;
  logic out1_q, out1_d, out2_q, out2_d;
  logic leftPhase;
  assign leftPhase = (fmt_q == SASO_FMT_I2S) ? channel_clock : !channel_clock; // RULE10 RULE13
  assign fifoPop = running && lEdge && leftPhase;
  always_comb begin
    hold_d = hold_q;
    sh1_d = sh1_q;
    sh2_d = sh2_q;
    bitCnt_d = bitCnt_q;
    out1_d = out1_q;
    out2_d = out2_q;
    if (!running) begin
      out1_d = 1'b0;
      out2_d = 1'b0;
      bitCnt_d = '0;
    end else begin
      if (lEdge) begin
        if (leftPhase) begin
          sh1_d = fifoValid ? fifoOut[4*WIDTH-1 -: WIDTH] : '0; // RULE9 RULE11
          sh2_d = fifoValid ? fifoOut[2*WIDTH-1 -: WIDTH] : '0; // RULE9
          hold_d = fifoValid ? {fifoOut[3*WIDTH-1 -: WIDTH], fifoOut[WIDTH-1:0]} : '0;
        end else begin
          sh1_d = hold_q[PAIR_WIDTH-1 -: WIDTH]; // RULE11
          sh2_d = hold_q[WIDTH-1:0];
        end
        bitCnt_d = '0;
        // i2s: this edge acts as the delay slot, msb follows on the next fall
        out1_d = 1'b0;
        out2_d = 1'b0;
        if (fmt_q == SASO_FMT_LJ) begin
          // msb goes out right at the channel clock edge
          out1_d = sh1_d[WIDTH-1]; // RULE8
          out2_d = sh2_d[WIDTH-1];
          sh1_d = {sh1_d[WIDTH-2:0], 1'b0};
          sh2_d = {sh2_d[WIDTH-2:0], 1'b0};
          bitCnt_d = 6'd1;
        end
      end else if (bFall) begin // RULE19
        if (bitCnt_q < 6'(WIDTH)) begin
          out1_d = sh1_q[WIDTH-1]; // RULE8 RULE10
          out2_d = sh2_q[WIDTH-1];
          sh1_d = {sh1_q[WIDTH-2:0], 1'b0};
          sh2_d = {sh2_q[WIDTH-2:0], 1'b0};
          bitCnt_d = bitCnt_q + 1'b1;
        end else begin
          out1_d = 1'b0; // RULE20
          out2_d = 1'b0; // RULE20
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_q <= '0;
      sh1_q <= '0;
      sh2_q <= '0;
      bitCnt_q <= '0;
      out1_q <= 1'b0;
      out2_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
      sh1_q <= sh1_d;
      sh2_q <= sh2_d;
      bitCnt_q <= bitCnt_d;
      out1_q <= out1_d;
      out2_q <= out2_d;
    end
  end

  // ==========================================
  // pins; data pin floats until stand-alone mode is entered so a pull-up can be seen
  assign bitClockOut = mBclk;
  assign channelClockOut = mLrck;
  assign bitClockOeN = !(running && !slave_q); // RULE2 RULE5
  assign channelClockOeN = !(running && !slave_q); // RULE3 RULE5
  assign fullPrecisionOut = out1_q;
  assign fullPrecisionOeN = !running; // RULE17
  assign lowDelayOut = out2_q;
endmodule : saso_serial_out
`default_nettype wire

/* verif/saso_serial_out_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module saso_serial_out_sva (
  // watched ports
  input wire logic clk,
  input wire logic rst,
  input wire logic sampleReady,
  input wire logic roleSelect,
  input wire logic bitClockOut,
  input wire logic bitClockOeN,
  input wire logic channelClockOut,
  input wire logic channelClockOeN,
  input wire logic fullPrecisionOeN,
  input wire logic controlPortMode,
  input wire logic standAlone
);
  // ========================================
  // cycles since reset release
  logic [8:0] runCnt_q;
  logic [8:0] runCnt_d;
  always_comb runCnt_d = rst ? 9'h000 : runCnt_q + {8'h00, ~&runCnt_q};
  always_ff @(posedge clk) runCnt_q <= runCnt_d;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_idle: assert property (disable iff (1'b0) $past(rst) && rst |->
    bitClockOeN && channelClockOeN && fullPrecisionOeN && sampleReady)
    else $error("pins not released in reset");
  a_bclk_div: assert property ($rose(bitClockOut) && !bitClockOeN |->
    ##2 $fell(bitClockOut) ##2 $rose(bitClockOut)) else $error("bit clock not clk/4");
  a_channel_clock_div: assert property ($rose(channelClockOut) && !channelClockOeN |->
    ##128 $fell(channelClockOut) ##128 $rose(channelClockOut)) else $error("channel_clock not clk/256");
  a_channel_clock_on_fall: assert property ($changed(channelClockOut) && !channelClockOeN |->
    $fell(bitClockOut)) else $error("channel_clock edge off bit clock fall");
  a_role_master: assert property (standAlone && !roleSelect |->
    !bitClockOeN && !channelClockOeN) else $error("master not driving clocks");
  a_role_slave: assert property (roleSelect || !standAlone |->
    bitClockOeN && channelClockOeN) else $error("clocks driven outside master");
  a_port_mode: assert property (controlPortMode |->
    fullPrecisionOeN && bitClockOeN && !standAlone) else $error("control mode drives pins");
  a_strap_early: assert property (standAlone || controlPortMode |->
    runCnt_q >= 9'h0F8) else $error("mode chosen too early");
  a_strap_late: assert property (runCnt_q == 9'h106 |->
    standAlone || controlPortMode) else $error("mode not chosen in time");
  a_data_driven: assert property (standAlone |-> !fullPrecisionOeN)
    else $error("data pin released in stand-alone");
  c_master: cover property (standAlone && !bitClockOeN);
  c_slave: cover property (standAlone && bitClockOeN);
  c_port: cover property (controlPortMode);
  c_full: cover property (!sampleReady);
endmodule : saso_serial_out_sva
bind saso_serial_out saso_serial_out_sva chk (.clk, .rst, .sampleReady, .roleSelect,
  .bitClockOut, .bitClockOeN, .channelClockOut, .channelClockOeN, .fullPrecisionOeN,
  .controlPortMode, .standAlone);
`default_nettype wire

/* verif/saso_audio_rx.sv */
`timescale 1ns/1ps
`default_nettype none
module saso_audio_rx (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link
  input wire logic i2sFormat,
  input wire logic slaveRole,
  input wire logic bitClock,
  input wire logic channelClock,
  input wire logic fullData,
  input wire logic lowData,
  output logic bitClockDrv,
  output logic channelClockDrv,
  // captured words
  output logic [23:0] fullL,
  output logic [23:0] fullR,
  output logic [23:0] lowL,
  output logic [23:0] lowR,
  output logic tailBits = 1'b0
);
  // ========================================
  // slave clocks, both cut from the master clock
  logic [7:0] divCnt_q = 8'h00;
  logic lastCh = 1'b0;
  logic [5:0] slot = 6'h00;
  logic [5:0] pos;
  logic [23:0] shF;
  logic [23:0] shL;
  always @(posedge clk) divCnt_q <= rst ? 8'h00 : divCnt_q + 8'h01;
  assign bitClockDrv = divCnt_q[1];
  assign channelClockDrv = divCnt_q[7];
  // ========================================
  // capture on rising bit clock
  always @(posedge bitClock) begin
    slot = (channelClock != lastCh) ? 6'h00 : slot + 6'h01;
    lastCh = channelClock;
    // slave data trails our clocks by the device's synchroniser, one bit late
    pos = slot - {5'h00, i2sFormat} - {5'h00, slaveRole};
    if (pos < 6'h18) begin
      shF = {shF[22:0], fullData};
      shL = {shL[22:0], lowData};
    end else begin
      tailBits = tailBits | fullData | lowData;
    end
    if (pos == 6'h17 && (channelClock ^ i2sFormat)) begin
      fullR = shF;
      lowR = shL;
    end else if (pos == 6'h17) begin
      fullL = shF;
      lowL = shL;
    end
  end
endmodule : saso_audio_rx
`default_nettype wire

/* verif/standalone_audio_serial_out_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module standalone_audio_serial_out_bench;
  import saso_pkg::*;
  logic clk = 1'b0, rst = 1'b1, sampleValid = 1'b0, sampleReady;
  logic [23:0] fullLeft = 24'h000000, fullRight = 24'h000000;
  logic [23:0] lowDelayLeft = 24'h000000, lowDelayRight = 24'h000000;
  logic roleSelect = 1'b0, formatSelect = 1'b0, strapLevel = 1'b0;
  logic bitClockOut, bitClockOeN, channelClockOut, channelClockOeN;
  logic fullPrecisionOut, fullPrecisionOeN, lowDelayOut, controlPortMode, standAlone;
  logic rxBclk, rxLrck, tailBits;
  logic [23:0] fl, fr, ll, lr;
  int errCount = 0, comparisons = 0, cycles = 0;
  wire logic bclk = bitClockOeN ? rxBclk : bitClockOut;
  wire logic channel_clock = channelClockOeN ? rxLrck : channelClockOut;
  wire logic fpData = fullPrecisionOeN ? strapLevel : fullPrecisionOut;
  saso_serial_out uut (.clk(clk), .rst(rst), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .fullLeft(fullLeft), .fullRight(fullRight),
    .lowDelayLeft(lowDelayLeft), .lowDelayRight(lowDelayRight), .roleSelect(roleSelect),
    .formatSelect(formatSelect), .bitClockIn(bclk), .bitClockOut(bitClockOut),
    .bitClockOeN(bitClockOeN), .channelClockIn(channel_clock), .channelClockOut(channelClockOut),
    .channelClockOeN(channelClockOeN), .fullPrecisionIn(fpData),
    .fullPrecisionOut(fullPrecisionOut), .fullPrecisionOeN(fullPrecisionOeN),
    .lowDelayOut(lowDelayOut), .controlPortMode(controlPortMode), .standAlone(standAlone));
  saso_audio_rx rx (.clk(clk), .rst(rst), .i2sFormat(formatSelect),
    .slaveRole(roleSelect), .bitClock(bclk),
    .channelClock(channel_clock), .fullData(fpData), .lowData(lowDelayOut), .bitClockDrv(rxBclk),
    .channelClockDrv(rxLrck), .fullL(fl), .fullR(fr), .lowL(ll), .lowR(lr),
    .tailBits(tailBits));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      errCount++;
      results();
    end
  end
  // ========================================
  // shared tasks
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errCount++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic start(input logic role, input logic fmt, input logic strap);
    @(posedge clk) #1 {roleSelect, formatSelect, strapLevel, rst} = {role, fmt, strap, 1'b1};
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 300 && !(standAlone || controlPortMode); i++) @(posedge clk);
    @(negedge clk);
  endtask : start
  task automatic push(input logic [95:0] v);
    @(posedge clk) #1 {fullLeft, fullRight, lowDelayLeft, lowDelayRight} = v;
    sampleValid = 1'b1;
    @(negedge clk);
    while (!sampleReady) @(negedge clk);
    @(posedge clk) #1 sampleValid = 1'b0;
  endtask : push
  // ========================================
  // scenarios
  task automatic test_link(input logic role, input logic fmt, input logic [95:0] v);
    start(role, fmt, 1'b0);
    check(standAlone, 1'b1);
    push(v);
    for (int i = 0; i < 1200 && {fl, fr, ll, lr} !== v; i++) @(posedge clk);
    check(fl, v[95:72]);
    check(fr, v[71:48]);
    check(ll, v[47:24]);
    check(lr, v[23:0]);
    check(tailBits, 1'b0);
    $display("link test done, role %0d format %0d", role, fmt);
  endtask : test_link
  task automatic test_fill;
    int n;
    logic r;
    n = 0;
    @(posedge clk) #1 sampleValid = 1'b1;
    repeat (40) begin
      @(negedge clk) r = sampleReady;
      n += r;
      @(posedge clk);
    end
    #1 sampleValid = 1'b0;
    check(n >= 32 && n <= 33, 1'b1);
    check(r, 1'b0);
    $display("fill test done");
  endtask : test_fill
  task automatic test_port;
    start(1'b0, 1'b0, 1'b1);
    check(controlPortMode, 1'b1);
    check(standAlone, 1'b0);
    check(fullPrecisionOeN, 1'b1);
    $display("port test done");
  endtask : test_port
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  initial begin
    test_link(1'b0, 1'b0, 96'h8A5C31_3C96E7_C0FFEE_15A5A5);
    test_fill();
    test_link(1'b1, 1'b1, 96'h7F00A5_800001_5A3C0F_E10F96);
    test_port();
    results();
  end
endmodule : standalone_audio_serial_out_bench
`default_nettype wire
